// ---- design/dasp_top.v ----
// Digital audio serial port: APB registers, clock master/slave and framing
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`include "dasp_regs.vh"
module dasp_top (
  input wire clk,
  input wire rstn,
  // APB register port
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // Link pins; each drive value has its own enable
  input wire bclk_in,
  output wire bclk_out,
  output wire bclk_oe,
  input wire wclk_in,
  output wire wclk_out,
  output wire wclk_oe,
  input wire sdin,
  output wire serial_data_out,
  output wire serial_data_out_oe,
  // Sample streams, LSB aligned
  input wire [31:0] tx_left,
  input wire [31:0] tx_right,
  output reg tx_taken,
  output reg [31:0] rx_left,
  output reg [31:0] rx_right,
  output reg rx_valid
);
  // Control registers and read decode
  reg [7:0] clk_mode_reg;
  reg [7:0] ctrl_reg;
  reg [7:0] slot_reg;
  reg [7:0] ofs_lo_reg;
  reg [7:0] ofs_hi_reg;
  reg frame_seen_reg;
  reg [7:0] rd_data;
  reg rd_hit;

  // Bus decode and synchronised pins
  wire [7:0] idx;
  wire wr_acc;
  wire bclk_s;
  wire wclk_s;
  wire sdin_s;

  assign idx = paddr[9:2];
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_acc = psel & penable & pwrite;

  // Decode; low address bits must be zero for a hit
  always @* begin
    rd_hit = (paddr[1:0] == 2'h0);
    case (idx)
      `DASP_IDX_CLK_MODE: rd_data = clk_mode_reg;
      `DASP_IDX_CTRL: rd_data = ctrl_reg;
      `DASP_IDX_SLOT: rd_data = slot_reg;
      `DASP_IDX_OFS_LO: rd_data = ofs_lo_reg;
      `DASP_IDX_OFS_HI: rd_data = ofs_hi_reg;
      `DASP_IDX_STATUS: rd_data = {7'h00, frame_seen_reg};
      default: begin
        rd_data = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Register writes take effect only in the access cycle
  // Masks drop writes to reserved bits, so those bits always read as zero
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clk_mode_reg <= `DASP_RST_CLK_MODE;
      ctrl_reg <= `DASP_RST_CTRL;
      slot_reg <= `DASP_RST_SLOT;
      ofs_lo_reg <= `DASP_RST_OFS;
      ofs_hi_reg <= `DASP_RST_OFS;
    end else if (wr_acc && rd_hit) begin
      case (idx)
        `DASP_IDX_CLK_MODE: clk_mode_reg <= pwdata[7:0] & `DASP_MASK_CLK_MODE;
        `DASP_IDX_CTRL: ctrl_reg <= pwdata[7:0] & `DASP_MASK_CTRL;
        `DASP_IDX_SLOT: slot_reg <= pwdata[7:0] & `DASP_MASK_SLOT;
        `DASP_IDX_OFS_LO: ofs_lo_reg <= pwdata[7:0] & `DASP_MASK_OFS_LO;
        `DASP_IDX_OFS_HI: ofs_hi_reg <= pwdata[7:0] & `DASP_MASK_OFS_HI;
        default: ;
      endcase
    end
  end

  // Read data is latched in the setup cycle so it is a flop in the access cycle
  // Unmapped or misaligned addresses raise pslverr and leave registers alone
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h00000000 : {24'h000000, rd_data};
      pslverr <= ~rd_hit;
    end
  end

  // Pin synchronisers
  dasp_sync u_bclk (.clk(clk), .rstn(rstn), .d(bclk_in), .q(bclk_s));
  dasp_sync u_wclk (.clk(clk), .rstn(rstn), .d(wclk_in), .q(wclk_s));
  dasp_sync u_sdin (.clk(clk), .rstn(rstn), .d(sdin), .q(sdin_s));

  // Control decode; the frame clock is driven only in master mode without
  // the force-input bit
  wire master = clk_mode_reg[`DASP_MASTER];
  wire wclk_drive = master & ~clk_mode_reg[`DASP_WCLK_IN];
  wire port_en = ctrl_reg[`DASP_EN];
  wire [1:0] fmt = ctrl_reg[`DASP_FMT];
  wire dsp = (fmt == `DASP_FMT_DSP);
  wire slot_mode = slot_reg[`DASP_SLOT_EN];
  wire [8:0] nbits = `DASP_BPW_BASE << clk_mode_reg[`DASP_BPW];
  // Offset is used as written; values past the usable maximum only push
  // the word further into the frame
  wire [10:0] offset = {ofs_hi_reg[`DASP_OFS_HI_BITS], ofs_lo_reg};
  reg [5:0] wlen;

  // Word length per channel
  always @* begin
    case (ctrl_reg[`DASP_WLEN])
      2'h0: wlen = `DASP_WL_16;
      2'h1: wlen = `DASP_WL_20;
      2'h2: wlen = `DASP_WL_24;
      default: wlen = `DASP_WL_32;
    endcase
  end

  // Channel enables; reserved count code enables nothing
  // Slot enables can only narrow what the channel count allows
  wire chn_l = (ctrl_reg[`DASP_CHN] == `DASP_CHN_LEFT) |
    (ctrl_reg[`DASP_CHN] == `DASP_CHN_BOTH);
  wire chn_r = (ctrl_reg[`DASP_CHN] == `DASP_CHN_BOTH);
  wire en_l = chn_l & (~slot_mode | slot_reg[`DASP_SLOT_L]);
  wire en_r = chn_r & (~slot_mode | slot_reg[`DASP_SLOT_R]);

  // Master bit clock divider
  // The rate is fixed at an 80 ns period; a slower link clock needs
  // slave mode with the host driving the bit clock
  reg [3:0] div_reg;
  reg bgen_reg;
  wire div_end = (div_reg == `DASP_BCLK_LAST);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 4'h0;
      bgen_reg <= 1'b0;
    end else if (!master) begin
      div_reg <= 4'h0;
      bgen_reg <= 1'b0;
    end else if (div_end) begin
      div_reg <= 4'h0;
      bgen_reg <= ~bgen_reg;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  // Slave bit clock edge finder on the synchronised pin
  // Edges lag the pin by about three cycles; data in and the bit clock pass
  // equal synchronisers, so their relative timing is kept
  reg bprev_reg;
  wire beff_s = bclk_s ^ clk_mode_reg[`DASP_BCLK_POL];
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bprev_reg <= 1'b0;
    end else begin
      bprev_reg <= beff_s;
    end
  end

  // One-cycle events: rise samples data, fall launches data
  // In master mode they come from the divider, not from the pin, so the
  // round trip through the pad does not delay the framer
  wire rise_ev = master ? (div_end & ~bgen_reg) : (beff_s & ~bprev_reg);
  wire fall_ev = master ? (div_end & bgen_reg) : (~beff_s & bprev_reg);

  // Master frame counter, advanced on each launching edge
  // Reset count makes the first launching edge begin a frame at zero
  reg [8:0] mcnt_reg;
  reg wgen_reg;
  wire [8:0] mcnt_next = (mcnt_reg >= nbits - 9'h001) ? 9'h000 : mcnt_reg + 9'h001;
  wire wgen_next = dsp ? (mcnt_next == 9'h000) : (mcnt_next >= {1'b0, nbits[8:1]});
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mcnt_reg <= `DASP_MCNT_RST;
      wgen_reg <= 1'b0;
    end else if (!master) begin
      mcnt_reg <= `DASP_MCNT_RST;
      wgen_reg <= 1'b0;
    end else if (fall_ev) begin
      mcnt_reg <= mcnt_next;
      wgen_reg <= wgen_next;
    end
  end

  // Frame clock as seen by the framer; generated level is already internal polarity
  wire weff_s = wclk_s ^ clk_mode_reg[`DASP_WCLK_POL];
  wire wclk_now = wclk_drive ? wgen_next : weff_s;

  // Framing state updated on launching edges
  // Position saturates so a stopped frame clock cannot wrap into a new word
  reg wprev_reg;
  reg [11:0] fpos_reg;
  reg [11:0] half_reg;
  reg drv_valid_reg;
  reg drv_chan_reg;
  reg [5:0] drv_idx_reg;
  reg sdout_reg;
  reg [31:0] txl_reg;
  reg [31:0] txr_reg;
  reg [11:0] base;
  reg [11:0] rel;
  reg chan_next;
  reg valid_next;
  reg [5:0] idx_next;
  reg [31:0] word_sel;
  reg [4:0] bit_sel;
  // Two-phase formats start each half on a change; DSP only on the rise
  wire w_start = dsp ? (wclk_now & ~wprev_reg) : (wclk_now != wprev_reg);
  wire f_start = w_start & (dsp | ~wclk_now);
  wire [11:0] fpos_next = w_start ? 12'h000 :
    ((fpos_reg == `DASP_FPOS_MAX) ? fpos_reg : fpos_reg + 12'h001);

  // Bit position within the channel for the bit about to be launched
  always @* begin
    case (fmt)
      `DASP_FMT_I2S: base = 12'h001 + {1'b0, offset};
      `DASP_FMT_RJ: base = half_reg - {6'h00, wlen} + {1'b0, offset};
      default: base = {1'b0, offset};
    endcase
    rel = fpos_next - base;
    if (dsp) begin
      chan_next = (rel >= {6'h00, wlen});
      idx_next = chan_next ? (rel[5:0] - wlen) : rel[5:0];
      valid_next = (fpos_next >= base) && (rel < {5'h00, wlen, 1'b0});
    end else begin
      chan_next = wclk_now;
      idx_next = rel[5:0];
      valid_next = (fpos_next >= base) && (rel < {6'h00, wlen});
    end
    valid_next = valid_next & (chan_next ? en_r : en_l) & port_en;
    word_sel = chan_next ? txr_reg : txl_reg;
    bit_sel = wlen[4:0] - 5'h01 - idx_next[4:0];
  end

  // Launch side: one bit per falling edge, MSB first
  // Words are registered at frame start, so a mid-frame update waits for the next frame; in left-justified
  // and DSP formats at zero offset the first left bit of a frame still comes from the previous word
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wprev_reg <= 1'b0;
      fpos_reg <= `DASP_FPOS_MAX;
      half_reg <= `DASP_HALF_RST;
      drv_valid_reg <= 1'b0;
      drv_chan_reg <= 1'b0;
      drv_idx_reg <= 6'h00;
      sdout_reg <= 1'b0;
      txl_reg <= 32'h00000000;
      txr_reg <= 32'h00000000;
      tx_taken <= 1'b0;
    end else begin
      tx_taken <= 1'b0;
      if (fall_ev) begin
        wprev_reg <= wclk_now;
        fpos_reg <= fpos_next;
        if (w_start && !dsp) begin
          half_reg <= fpos_reg + 12'h001;
        end
        if (f_start && port_en) begin
          txl_reg <= tx_left;
          txr_reg <= tx_right;
          tx_taken <= 1'b1;
        end
        drv_valid_reg <= valid_next;
        drv_chan_reg <= chan_next;
        drv_idx_reg <= idx_next;
        // Samples taken at this frame start are used from the next launching edge on
        sdout_reg <= valid_next & word_sel[bit_sel];
      end
    end
  end

  // Capture side: shift on rising edges while a bit is valid
  // Words are LSB aligned; bits above the word length read as zero
  reg [31:0] rx_sh_reg;
  wire [31:0] rx_sh_next = (drv_idx_reg == 6'h00) ? {31'h00000000, sdin_s} :
    {rx_sh_reg[30:0], sdin_s};
  wire rx_last = (drv_idx_reg == wlen - 6'h01);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_sh_reg <= 32'h00000000;
      rx_left <= 32'h00000000;
      rx_right <= 32'h00000000;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (rise_ev && drv_valid_reg) begin
        rx_sh_reg <= rx_sh_next;
        if (rx_last && !drv_chan_reg) begin
          rx_left <= rx_sh_next;
          rx_valid <= ~en_r;
        end
        if (rx_last && drv_chan_reg) begin
          rx_right <= rx_sh_next;
          rx_valid <= 1'b1;
        end
      end
    end
  end

  // Status: a frame start has been seen since the port was enabled
  // Clearing on disable means software sees only frames of this session
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frame_seen_reg <= 1'b0;
    end else if (!port_en) begin
      frame_seen_reg <= 1'b0;
    end else if (fall_ev && f_start) begin
      frame_seen_reg <= 1'b1;
    end
  end

  // Clock pins; slave mode leaves both undriven
  assign bclk_oe = master;
  assign bclk_out = bgen_reg ^ clk_mode_reg[`DASP_BCLK_POL];
  assign wclk_oe = wclk_drive;
  assign wclk_out = wgen_reg ^ clk_mode_reg[`DASP_WCLK_POL];

  // In slot mode current enables also gate the pin, so a channel switched off in
  // mid-word releases the line at once rather than at the next bit
  wire drv_en_now = drv_valid_reg & (drv_chan_reg ? en_r : en_l);

  // Data pin; in slot mode the line is released between our own bits
  assign serial_data_out = sdout_reg;
  assign serial_data_out_oe = port_en & slot_reg[`DASP_OE] &
    (~slot_mode | drv_en_now);
endmodule // dasp_top

// ---- design/dasp_regs.vh ----
// Register map, field positions, reset values and timing constants of the serial port
// Notes on behaviour
// - Master bit drives both clocks, else inputs
// - Frame-clock force-input keeps frame pin input
// - Frame-clock invert bit flips its polarity
// - Bit-clock invert bit flips its polarity
// - Master frame holds 32/64/128/256 bit clocks
// - Port enable gates all data transfer
// - Channel count: none, left, both; 11 reserved
// - Word length 16/20/24/32 bits per channel
// - Format: I2S, left, right justified, DSP
// - Slot mode floats data out when idle
// - Output-drive bit zero floats data out
// - Slot field bit0 left, bit1 right enable
// - Data delayed by 11-bit bit-clock offset
`ifndef DASP_REGS_VH
`define DASP_REGS_VH
// Register indices; byte address is four times the index
`define DASP_IDX_CLK_MODE 8'h2b
`define DASP_IDX_CTRL 8'h2c
`define DASP_IDX_SLOT 8'h2d
`define DASP_IDX_OFS_LO 8'h30
`define DASP_IDX_OFS_HI 8'h31
`define DASP_IDX_STATUS 8'h32
// Reset values
`define DASP_RST_CLK_MODE 8'h01
`define DASP_RST_CTRL 8'h28
`define DASP_RST_SLOT 8'h40
`define DASP_RST_OFS 8'h00
// Writable bit masks
`define DASP_MASK_CLK_MODE 8'h9f
`define DASP_MASK_CTRL 8'hbf
`define DASP_MASK_SLOT 8'hc3
`define DASP_MASK_OFS_LO 8'hff
`define DASP_MASK_OFS_HI 8'h07
// Field positions
`define DASP_MASTER 7
`define DASP_WCLK_IN 4
`define DASP_WCLK_POL 3
`define DASP_BCLK_POL 2
`define DASP_BPW 1:0
`define DASP_EN 7
`define DASP_CHN 5:4
`define DASP_WLEN 3:2
`define DASP_FMT 1:0
`define DASP_SLOT_EN 7
`define DASP_OE 6
`define DASP_SLOT_CH 1:0
// Format codes
`define DASP_FMT_I2S 2'h0
`define DASP_FMT_LJ 2'h1
`define DASP_FMT_RJ 2'h2
`define DASP_FMT_DSP 2'h3
// Channel count codes
`define DASP_CHN_LEFT 2'h1
`define DASP_CHN_BOTH 2'h2
// Master bit clock: half period in ns and in clk cycles at 100 MHz
`define DASP_CLK_NS 10
`define DASP_BCLK_HALF_NS 40
`define DASP_BCLK_HALF_CYC (`DASP_BCLK_HALF_NS / `DASP_CLK_NS)
// Base frame length in bit clocks
`define DASP_BPW_BASE 9'h020
// Master divider end count: half period in clk cycles minus one
`define DASP_BCLK_LAST 4'h3
// Word lengths in bits per channel
`define DASP_WL_16 6'h10
`define DASP_WL_20 6'h14
`define DASP_WL_24 6'h18
`define DASP_WL_32 6'h20
// Slot enable bits and the used part of the offset high byte
`define DASP_SLOT_L 0
`define DASP_SLOT_R 1
`define DASP_OFS_HI_BITS 2:0
// Framer reset values: frame counter, half frame length, saturated position
`define DASP_MCNT_RST 9'h1ff
`define DASP_HALF_RST 12'h020
`define DASP_FPOS_MAX 12'hfff
`endif

// ---- design/dasp_sync.v ----
// Two-flop synchroniser for one asynchronous pin
`timescale 1ns/1ps
module dasp_sync (
  input wire clk,
  input wire rstn,
  input wire d,
  output wire q
);
  reg s1_reg;
  reg s2_reg;

  // Only the second flop is read outside
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
    end
  end

  assign q = s2_reg;
endmodule // dasp_sync

// ---- tb/dasp_chk.sv ----
// Checker for clock direction, bit clock timing and data pin drive
`timescale 1ns/1ps
module dasp_chk (
  input wire clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  input wire bclk_out,
  input wire bclk_oe,
  input wire wclk_oe,
  input wire serial_data_out_oe,
  input wire tx_taken,
  input wire rx_valid
);
  reg [7:0] ck_reg, ct_reg, sl_reg;
  reg [1:0] age_reg;
  wire q = age_reg == 2'h3;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Shadow of control bytes; q skips the cycles a write needs to act
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ck_reg <= 8'h01;
      ct_reg <= 8'h28;
      sl_reg <= 8'h40;
      age_reg <= 2'h3;
    end else if (psel && penable && pwrite) begin
      age_reg <= 2'h0;
      if (paddr == 10'h0ac) ck_reg <= pwdata[7:0];
      if (paddr == 10'h0b0) ct_reg <= pwdata[7:0];
      if (paddr == 10'h0b4) sl_reg <= pwdata[7:0];
    end else if (!q) begin
      age_reg <= age_reg + 2'h1;
    end
  end
  a_bclk_dir: assert property (q |-> bclk_oe == ck_reg[7]) else $error("bclk dir");
  a_wclk_dir: assert property (q |-> wclk_oe == (ck_reg[7] && !ck_reg[4]))
    else $error("wclk dir");
  a_bclk_half: assert property (disable iff (!rstn || !q)
    bclk_oe && $changed(bclk_out) |=> $stable(bclk_out) [*3] ##1 $changed(bclk_out))
    else $error("bclk half");
  a_idle_quiet: assert property (q && !ct_reg[7] |-> !tx_taken && !rx_valid)
    else $error("data while off");
  a_idle_float: assert property (q && !ct_reg[7] |-> !serial_data_out_oe)
    else $error("pin while off");
  a_drive_off: assert property (q && !sl_reg[6] |-> !serial_data_out_oe)
    else $error("pin with drive off");
  a_slot_none: assert property (q && sl_reg[7] && !sl_reg[1:0] |-> !serial_data_out_oe)
    else $error("pin with no slot");
  a_chn_none: assert property (q && ct_reg[5:4] == 2'h0 |-> !rx_valid)
    else $error("word with no channel");
  c_taken: cover property (tx_taken);
  c_slot: cover property (sl_reg[7] && serial_data_out_oe);
  c_half: cover property (bclk_oe && $rose(bclk_out));
endmodule // dasp_chk
bind dasp_top dasp_chk chk (.*);

// ---- tb/dasp_host.sv ----
// Host side of the link: slave clocks with fixed words, or echo of our output
`timescale 1ns/1ps
module dasp_host (
  input wire run,
  input wire loop,
  input wire sdo,
  input wire sdo_oe,
  output logic bclk,
  output logic wclk,
  output wire sdin
);
  logic hd = 0;
  logic [15:0] w;
  // Echo never drives over our slots; a floating pin shows the opposite level
  assign sdin = loop ? (sdo_oe ? sdo : ~sdo) : hd;
  // Clocks run only within frames: 64 bit clocks, I2S, 16-bit words
  initial begin
    bclk = 1;
    wclk = 1;
    forever begin
      wait (run);
      #3;
      for (int p = 0; p < 64; p++) begin
        #40;
        bclk = 0;
        wclk = p >= 32;
        w = p < 32 ? 16'ha5c3 : 16'h3c5a;
        hd = (p % 32 >= 1 && p % 32 <= 16) ? w[16 - p % 32] : ~hd;
        #40;
        bclk = 1;
      end
    end
  end
endmodule // dasp_host

// ---- tb/dasp_top_tb.sv ----
// Bench: registers, master frames, loopback formats, slot drive, slave receive
`timescale 1ns/1ps
module dasp_top_tb;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, run = 0, lp = 1, pe;
  logic [9:0] paddr = 0;
  logic [31:0] pwdata = 0, tx_left = 0, tx_right = 0, rd;
  wire [31:0] prdata, rx_left, rx_right;
  wire pready, pslverr, bclk_out, bclk_oe, wclk_out, wclk_oe, serial_data_out, hb, hw;
  wire serial_data_out_oe, tx_taken, rx_valid, bclk_in, wclk_in, sdin;
  int miscompares = 0, check_count = 0;
  dasp_top uut (.*);
  dasp_host host (.run, .loop(lp), .sdo(serial_data_out), .sdo_oe(serial_data_out_oe),
    .bclk(hb), .wclk(hw), .sdin);
  // Whoever enables its driver owns the clock wire
  assign bclk_in = bclk_oe ? bclk_out : hb;
  assign wclk_in = wclk_oe ? wclk_out : hw;
  always #5 clk = ~clk;
  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  // One transfer; the request stands until pready is seen at an edge
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    pe = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic cfg(input logic [7:0] t, s, o);
    apb(1'b1, 10'h0b0, t);
    apb(1'b1, 10'h0b4, s);
    apb(1'b1, 10'h0c0, o);
  endtask
  // Bounded wait for received words, sampled away from the clock edge
  task automatic wait_rv(input int c);
    for (int k = 0; k < 9000 && c > 0; k++) begin
      @(negedge clk);
      c -= rx_valid;
    end
    chk("rx wait", 0, c);
  endtask
  task automatic t_regs;
    logic [9:0] a[5] = '{10'h0ac, 10'h0b0, 10'h0b4, 10'h0c0, 10'h0c4};
    logic [7:0] r[5] = '{8'h01, 8'h28, 8'h40, 8'h00, 8'h00};
    logic [7:0] m[5] = '{8'h9f, 8'hbf, 8'hc3, 8'hff, 8'h07};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, a[i], 8'h00);
      chk("reset", {24'h0, r[i]}, rd);
      apb(1'b1, a[i], 8'hff);
      apb(1'b0, a[i], 8'h00);
      chk("bits", {24'h0, m[i]}, rd);
      apb(1'b1, a[i], 8'h80);
    end
    apb(1'b0, 10'h3fc, 8'h00);
    chk("unmapped", 32'h1, {31'h0, pe} | rd);
  endtask
  task automatic t_master;
    int n;
    logic pw, pb;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 10'h0ac, {6'h20, c[1:0]});
      n = -1;
      for (int k = 0; k < 6000; k++) begin
        pw = wclk_out;
        pb = bclk_out;
        @(negedge clk);
        if (wclk_out && !pw && n >= 0) break;
        if (wclk_out && !pw) n = 0;
        if (bclk_out && !pb && n >= 0) n++;
      end
      chk("bclks", 32 << c, n);
    end
  endtask
  // Echo through the host; the received word is the sent one cut to width
  task automatic t_loop(input logic [7:0] t, o);
    logic [31:0] l, m;
    l = 32'hc3a5_96e1 ^ {4{t}};
    m = 32'hffff_ffff >> (t[3:2] == 2'h3 ? 0 : 16 - 4 * t[3:2]);
    cfg(t, 8'h40, o);
    tx_left <= l;
    tx_right <= ~l;
    wait_rv(4);
    chk("left", l & m, rx_left);
    chk("right", ~l & m, rx_right);
  endtask
  task automatic t_slot;
    int n = 0;
    int t = 0;
    cfg(8'ha0, 8'hc1, 8'h00);
    wait_rv(2);
    repeat (1024) begin
      @(negedge clk);
      n += serial_data_out_oe;
      t += tx_taken;
    end
    chk("slot drive", 16 * 8, n);
    chk("tx taken", 1, t);
    apb(1'b0, 10'h0c8, 8'h00);
    chk("frame seen", 1, rd);
  endtask
  task automatic t_slave;
    lp <= 0;
    apb(1'b1, 10'h0ac, 8'h00);
    cfg(8'ha0, 8'h40, 8'h00);
    run <= 1;
    wait_rv(3);
    run <= 0;
    chk("slave left", 32'ha5c3, rx_left);
    chk("slave right", 32'h3c5a, rx_right);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    static logic [7:0] tc[8] = '{8'ha0, 8'ha4, 8'ha8, 8'hac, 8'ha9, 8'haa, 8'hab, 8'ha0};
    repeat (10) @(posedge clk);
    rstn <= 1;
    t_regs;
    t_master;
    apb(1'b1, 10'h0ac, 8'h82);
    for (int i = 0; i < 8; i++) t_loop(tc[i], i == 7 ? 8'h05 : 8'h00);
    t_slot;
    t_slave;
    test_done;
  end
  // Hang guard, well past the expected run
  initial begin
    #900us;
    miscompares++;
    test_done;
  end
endmodule // dasp_top_tb
